/* File: hlo_loop_input_options.sv */
// Loop and input options register with the datapath it steers.
// Assumes the serial bus decoder delivers a write strobe for this register,
// and that mode, sample and level inputs come from logic on sys_clk_in.
// Functional notes
// - two-bit gate threshold, off/2/4/8%, reset 2
// - bit 5 selects rotor open loop, reset open
// - bit 4 set disables supply compensation
// - compensation keeps amplitude constant over supply
// - bit 3 selects signed or unsigned live samples
// - bit 2 refresh once or twice per cycle
// - bit 1 selects duty or analog input
// - bit 0 linear open loop, pin over 128
`timescale 1ns/1ps
`default_nettype none
module hlo_loop_input_options
  import hlo_pkg::*;
(
  input wire logic sys_clk_in, // System clock, 200 MHz.
  input wire logic sys_rst_in, // Synchronous reset, high.
  input wire logic reg_wr_en_in, // Write strobe for this register.
  input wire logic [7:0] reg_wdata_in, // Write data.
  output logic [7:0] reg_rdata_out, // Stored register value.
  input wire logic actuator_linear_in, // 1 linear resonant, 0 rotating mass.
  input wire logic live_playback_mode_in, // Live playback mode active.
  input wire logic ext_input_mode_in, // External input mode active.
  input wire logic [7:0] live_sample_in, // Host-written live sample.
  input wire logic [7:0] engine_amp_in, // Amplitude from playback engine.
  input wire logic [7:0] duty_level_in, // Measured pin duty cycle.
  input wire logic [7:0] analog_level_in, // Converted pin level.
  input wire logic [7:0] supply_level_in, // Supply measurement code.
  input wire logic half_cycle_in, // Pulse at each resonance half cycle.
  input wire logic input_trigger_pin_in, // Asynchronous trigger pin.
  output logic [7:0] drive_amp_out, // Compensated drive amplitude.
  output logic drive_brake_out, // Negative drive (braking) request.
  output logic rotor_loop_bypass_out, // Rotating mass runs open loop.
  output logic linear_loop_bypass_out, // Linear actuator runs open loop.
  output logic commutation_out, // Open-loop commutation phase.
  output logic amp_update_out // Pulse: refresh linear drive amplitude.
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic [6:0] div_cnt;
    logic commut;
    logic half_sel;
    logic update;
    logic brake;
  } hlo_state_t;

  hlo_state_t q_ff;
  hlo_state_t nxt_q;
  logic [7:0] src_amp;
  logic [7:0] ext_amp;
  logic pin_rise;
  logic duty_open;

  // Turns a live sample into a drive magnitude on the full 8-bit scale.
  // Unsigned samples pass as they are; signed ones lose their sign bit, which becomes the brake request.
  // The most negative signed code has no positive twin in seven bits, so it gives no drive at all.
  function automatic logic [7:0] live_magnitude(input logic [7:0] sample, input logic unsigned_fmt);
    logic [6:0] mag;
    mag = sample[6:0];
    if (unsigned_fmt)
    begin
      live_magnitude = sample;
    end
    else
    begin
      if (sample[7])
      begin
        mag = (~sample[6:0]) + 7'h01;
      end
      live_magnitude = {mag, 1'b0};
    end
  endfunction : live_magnitude

  // Picks the pin reading for external input and zeroes anything under the noise gate.
  // A level equal to the threshold passes, so gate code 0 lets every level through.
  function automatic logic [7:0] gated_level(
    input logic [7:0] duty,
    input logic [7:0] analog,
    input logic analog_sel,
    input logic [1:0] gate_code
  );
    logic [7:0] level;
    level = analog_sel ? analog : duty;
    if (level < hlo_gate_level(gate_code))
    begin
      level = 8'h00;
    end
    gated_level = level;
  endfunction : gated_level

  // Decides whether a half-cycle pulse refreshes the linear drive amplitude.
  // At the slow rate only every second pulse counts, which keeps both half cycles of the drive alike.
  function automatic logic refresh_due(input logic twice_rate, input logic odd_half);
    refresh_due = twice_rate | odd_half;
  endfunction : refresh_due

  hlo_shape_if shape ();

  hlo_scaler u_scaler (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .sh(shape.scaler)
  );

  // Next-state logic for the register and its datapath.
  always_comb
  begin
    nxt_q = q_ff;
    src_amp = engine_amp_in;
    ext_amp = 8'h00;
    pin_rise = q_ff.pin_s2 & ~q_ff.pin_d;
    duty_open = actuator_linear_in & q_ff.ctrl[HLO_LIN_BIT] & ext_input_mode_in & ~q_ff.ctrl[HLO_PIN_BIT];

    // Whole-register write, no side effects.
    if (reg_wr_en_in)
    begin
      nxt_q.ctrl = reg_wdata_in;
    end

    // Two-stage pin synchroniser, then an edge reference.
    // The pin is asynchronous, so only the second stage feeds logic; a rise is seen about three cycles late.
    // Both stages clear to the pin's low idle level, so leaving reset never fakes a rise.
    nxt_q.pin_s1 = input_trigger_pin_in;
    nxt_q.pin_s2 = q_ff.pin_s1;
    nxt_q.pin_d = q_ff.pin_s2;

    // Open-loop linear drive from a duty-cycle pin: the commutation phase flips once per 128
    // synchronised pin rises, so commutations come at the pin frequency over 128.
    // Leaving that mode clears the divider, so the next entry starts a fresh count.
    if (duty_open)
    begin
      if (pin_rise)
      begin
        nxt_q.div_cnt = q_ff.div_cnt + 7'h01;
        if (q_ff.div_cnt == HLO_DIV_LAST)
        begin
          nxt_q.commut = ~q_ff.commut;
        end
      end
    end
    else
    begin
      nxt_q.div_cnt = '0;
    end

    // Refresh on every half-cycle pulse or on every second one; half_sel tracks which half is next.
    // The first pulse after reset is an even one, so at the slow rate it brings no refresh.
    nxt_q.update = 1'b0;
    if (half_cycle_in)
    begin
      nxt_q.half_sel = ~q_ff.half_sel;
      nxt_q.update = refresh_due(q_ff.ctrl[HLO_RATE_BIT], q_ff.half_sel);
    end

    // External input: duty or analog level, then the noise gate.
    // The gate sits only on this path; engine and live samples are never gated.
    ext_amp = gated_level(duty_level_in, analog_level_in, q_ff.ctrl[HLO_PIN_BIT],
      q_ff.ctrl[HLO_GATE_HI:HLO_GATE_LO]);

    // Amplitude source; live playback beats external input, which beats the engine.
    // Signed samples carry braking in their sign, and the brake flop matches the scaler's latency.
    nxt_q.brake = 1'b0;
    if (live_playback_mode_in)
    begin
      if (q_ff.ctrl[HLO_FMT_BIT])
      begin
        src_amp = live_magnitude(live_sample_in, 1'b1);
      end
      else
      begin
        nxt_q.brake = live_sample_in[7];
        src_amp = live_magnitude(live_sample_in, 1'b0);
      end
    end
    else if (ext_input_mode_in)
    begin
      src_amp = ext_amp;
    end
  end

  // State register; reset loads the documented field defaults.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      // Each field is loaded once: the option register takes its power-on value and datapath state clears.
      q_ff.ctrl <= HLO_REG_RESET;
      q_ff.pin_s1 <= 1'b0;
      q_ff.pin_s2 <= 1'b0;
      q_ff.pin_d <= 1'b0;
      q_ff.div_cnt <= '0;
      q_ff.commut <= 1'b0;
      q_ff.half_sel <= 1'b0;
      q_ff.update <= 1'b0;
      q_ff.brake <= 1'b0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Scaler hookup; the scaler registers, so brake is taken from a flop of matching age.
  // Control bits act one cycle after a write lands, and the drive amplitude follows one cycle later.
  assign shape.amp = src_amp;
  assign shape.comp_off = q_ff.ctrl[HLO_RAIL_BIT];
  assign shape.supply = supply_level_in;

  // Outputs.
  // Bypass flags are combinational from the actuator kind, so they follow a kind change at once.
  assign reg_rdata_out = q_ff.ctrl;
  assign drive_amp_out = shape.result;
  assign drive_brake_out = q_ff.brake;
  assign rotor_loop_bypass_out = ~actuator_linear_in & q_ff.ctrl[HLO_ROTOR_BIT];
  assign linear_loop_bypass_out = actuator_linear_in & q_ff.ctrl[HLO_LIN_BIT];
  assign commutation_out = q_ff.commut;
  assign amp_update_out = q_ff.update;
endmodule : hlo_loop_input_options
`default_nettype wire

/* File: hlo_loop_input_options_tb.sv */
// Self-checking testbench for the loop and input options register.
// Assumes the design package is compiled first; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module hlo_loop_input_options_tb;
  import hlo_pkg::*;
  logic sys_clk_in, sys_rst_in, wr, lin, live, ext, half, pin, brk, rbyp, lbyp, comm, upd;
  logic [7:0] wd, rd, samp, eng, duty, ana, sup, amp;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  hlo_loop_input_options dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_en_in(wr),
    .reg_wdata_in(wd), .reg_rdata_out(rd), .actuator_linear_in(lin), .live_playback_mode_in(live),
    .ext_input_mode_in(ext), .live_sample_in(samp), .engine_amp_in(eng), .duty_level_in(duty),
    .analog_level_in(ana), .supply_level_in(sup), .half_cycle_in(half), .input_trigger_pin_in(pin),
    .drive_amp_out(amp), .drive_brake_out(brk), .rotor_loop_bypass_out(rbyp),
    .linear_loop_bypass_out(lbyp), .commutation_out(comm), .amp_update_out(upd));
  // Compares and counts; four-state equality so an unknown bit matches only an unknown bit.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic wreg(input logic [7:0] v);
    wr = 1;
    wd = v;
    step(1);
    wr = 0;
  endtask : wreg
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Back-to-back writes, with the actuator kind flipping to steer both bypass outputs.
  task automatic t_regs;
    logic [7:0] vals [4];
    vals = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
    check("reset value", rd, HLO_REG_RESET);
    check("rotor bypass at reset", rbyp, 8'h01);
    wr = 1;
    for (int i = 0; i < 4; i++)
    begin
      wd = vals[i];
      lin = i[0];
      step(1);
      check("readback", rd, vals[i]);
      check("rotor bypass", rbyp, {7'h00, !lin & vals[i][5]});
      check("linear bypass", lbyp, {7'h00, lin & vals[i][0]});
    end
    wr = 0;
    step(1);
  endtask : t_regs
  // Each gate code passes a level at its threshold; codes 1 to 3 block one step below it, code 0 passes it.
  task automatic t_gate;
    logic [7:0] thr [4];
    thr = '{HLO_GATE_OFF, HLO_GATE_2PCT, HLO_GATE_4PCT, HLO_GATE_8PCT};
    ext = 1;
    for (int c = 0; c < 4; c++)
    begin
      wreg({2'(c), 6'h10});
      duty = thr[c];
      step(3);
      check("gate pass", amp, thr[c]);
      duty = thr[c] - 8'h01;
      step(3);
      check("gate block", amp, (c == 0) ? duty : 8'h00);
    end
    wreg(8'h12);
    ana = 8'h33;
    step(3);
    check("analog input", amp, 8'h33);
    ext = 0;
  endtask : t_gate
  // A negative sample brakes when signed and drives plainly when unsigned.
  task automatic t_live;
    live = 1;
    samp = 8'hC0;
    wreg(8'h10);
    step(3);
    check("signed brake", brk, 8'h01);
    check("signed amplitude", amp, 8'h80);
    wreg(8'h18);
    step(3);
    check("unsigned brake", brk, 8'h00);
    check("unsigned amplitude", amp, 8'hC0);
    live = 0;
  endtask : t_live
  // Half supply doubles the drive and saturates; disabling compensation passes it through.
  task automatic t_comp;
    sup = 8'h40;
    eng = 8'h30;
    wreg(8'h00);
    step(3);
    check("compensated", amp, 8'h60);
    eng = 8'h90;
    step(3);
    check("saturated", amp, 8'hFF);
    wreg(8'h10);
    step(3);
    check("compensation off", amp, 8'h90);
    sup = 8'h80;
  endtask : t_comp
  // Four half-cycle pulses give four refreshes or two, whatever the starting phase.
  task automatic t_upd;
    int n;
    for (int b = 0; b < 2; b++)
    begin
      n = 0;
      wreg({5'h00, b[0], 2'h0});
      repeat (4)
      begin
        half = 1;
        step(1);
        half = 0;
        n += upd;
        step(1);
        n += upd;
      end
      check("refresh count", 8'(n), (b == 1) ? 8'h04 : 8'h02);
    end
  endtask : t_upd
  // The commutation phase holds over 127 pin rises and flips on the 128th.
  task automatic t_comm;
    logic c0;
    lin = 1;
    ext = 1;
    wreg(8'h11);
    step(2);
    c0 = comm;
    repeat (HLO_PIN_DIV)
    begin
      check("commutation held", comm, {7'h00, c0});
      pin = 1;
      step(2);
      pin = 0;
      step(6);
    end
    check("commutation toggled", comm, {7'h00, !c0});
  endtask : t_comm
  initial
  begin
    sys_clk_in = 0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // A hang is cut short well past the roughly 1100 cycles the run needs.
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    {wr, lin, live, ext, half, pin, wd, samp, eng, duty, ana} = '0;
    sup = 8'h80;
    sys_rst_in = 1;
    step(6);
    sys_rst_in = 0;
    t_regs();
    t_gate();
    t_live();
    t_comp();
    t_upd();
    t_comm();
    complete_run();
  end
endmodule : hlo_loop_input_options_tb
`default_nettype wire

/* File: hlo_options_chk.sv */
// Assertion checker for the loop and input options register, watching top-level ports only.
// Assumes one clock domain with a synchronous active-high reset; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module hlo_options_chk
  import hlo_pkg::*;
(
  input wire logic sys_clk_in, // Clock.
  input wire logic sys_rst_in, // Reset, high.
  input wire logic reg_wr_en_in, // Write strobe.
  input wire logic [7:0] reg_wdata_in, // Write data.
  input wire logic [7:0] reg_rdata_out, // Stored value.
  input wire logic actuator_linear_in, // Actuator kind.
  input wire logic live_playback_mode_in, // Live mode.
  input wire logic ext_input_mode_in, // External mode.
  input wire logic [7:0] engine_amp_in, // Engine amplitude.
  input wire logic [7:0] supply_level_in, // Supply code.
  input wire logic half_cycle_in, // Half-cycle pulse.
  input wire logic [7:0] drive_amp_out, // Drive amplitude.
  input wire logic rotor_loop_bypass_out, // Rotor open loop.
  input wire logic linear_loop_bypass_out, // Linear open loop.
  input wire logic amp_update_out // Update pulse.
);
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Engine path only; three settled cycles cover either amplitude latency.
  logic eng;
  assign eng = !live_playback_mode_in && !ext_input_mode_in;
  property p_wr; reg_wr_en_in |=> reg_rdata_out == $past(reg_wdata_in); endproperty
  a_wr: assert property (p_wr) else $error("write not stored");
  property p_hold; !reg_wr_en_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");
  property p_rst; $fell(sys_rst_in) |-> reg_rdata_out == HLO_REG_RESET; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_rotor; rotor_loop_bypass_out == (!actuator_linear_in && reg_rdata_out[HLO_ROTOR_BIT]); endproperty
  a_rotor: assert property (p_rotor) else $error("rotor bypass wrong");
  property p_lin; linear_loop_bypass_out == (actuator_linear_in && reg_rdata_out[HLO_LIN_BIT]); endproperty
  a_lin: assert property (p_lin) else $error("linear bypass wrong");
  property p_upd; half_cycle_in && reg_rdata_out[HLO_RATE_BIT] |=> amp_update_out; endproperty
  a_upd: assert property (p_upd) else $error("update pulse missing");
  property p_raw; (eng && reg_rdata_out[HLO_RAIL_BIT] && $stable(engine_amp_in)) [*3] |->
    drive_amp_out == engine_amp_in; endproperty
  a_raw: assert property (p_raw) else $error("uncompensated amplitude wrong");
  property p_unity; (eng && !reg_rdata_out[HLO_RAIL_BIT] && supply_level_in == HLO_SUPPLY_NOM &&
    $stable(engine_amp_in)) [*3] |-> drive_amp_out == engine_amp_in; endproperty
  a_unity: assert property (p_unity) else $error("unity compensation wrong");
endmodule : hlo_options_chk
bind hlo_loop_input_options hlo_options_chk u_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .reg_wr_en_in(reg_wr_en_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .actuator_linear_in(actuator_linear_in), .live_playback_mode_in(live_playback_mode_in),
  .ext_input_mode_in(ext_input_mode_in), .engine_amp_in(engine_amp_in), .supply_level_in(supply_level_in),
  .half_cycle_in(half_cycle_in), .drive_amp_out(drive_amp_out), .rotor_loop_bypass_out(rotor_loop_bypass_out),
  .linear_loop_bypass_out(linear_loop_bypass_out), .amp_update_out(amp_update_out));
`default_nettype wire

/* File: hlo_pkg.sv */
// Constants for the loop and input options register and its datapath.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package hlo_pkg;
  // Register geometry and field positions.
  localparam int HLO_REG_W = 8;
  localparam int HLO_GATE_HI = 7;
  localparam int HLO_GATE_LO = 6;
  localparam int HLO_ROTOR_BIT = 5;
  localparam int HLO_RAIL_BIT = 4;
  localparam int HLO_FMT_BIT = 3;
  localparam int HLO_RATE_BIT = 2;
  localparam int HLO_PIN_BIT = 1;
  localparam int HLO_LIN_BIT = 0;
  // Reset value: gate code 2, rotor open loop, everything else zero.
  localparam logic [7:0] HLO_REG_RESET = 8'hA0;
  // Gate thresholds on a 0..255 scale: off, 2%, 4%, 8% rounded down.
  localparam logic [7:0] HLO_GATE_OFF = 8'h00;
  localparam logic [7:0] HLO_GATE_2PCT = 8'h05;
  localparam logic [7:0] HLO_GATE_4PCT = 8'h0A;
  localparam logic [7:0] HLO_GATE_8PCT = 8'h14;
  // Pin edges per commutation half period in duty-cycle open-loop mode.
  localparam int HLO_PIN_DIV = 128;
  localparam int HLO_DIV_W = 7;
  localparam logic [6:0] HLO_DIV_LAST = 7'h7F;
  // Supply code at which compensation is unity.
  localparam logic [7:0] HLO_SUPPLY_NOM = 8'h80;
  localparam logic [7:0] HLO_AMP_MAX = 8'hFF;

  // Maps a gate code to its amplitude threshold.
  function automatic logic [7:0] hlo_gate_level(input logic [1:0] code);
    case (code)
      2'b01: hlo_gate_level = HLO_GATE_2PCT;
      2'b10: hlo_gate_level = HLO_GATE_4PCT;
      2'b11: hlo_gate_level = HLO_GATE_8PCT;
      default: hlo_gate_level = HLO_GATE_OFF;
    endcase
  endfunction : hlo_gate_level
endpackage : hlo_pkg

/* File: hlo_scaler.sv */
// Supply compensation stage: scales the amplitude by nominal over supply.
// Assumes supply codes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hlo_scaler
  import hlo_pkg::*;
(
  input wire logic sys_clk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset, high.
  hlo_shape_if.scaler sh // Amplitude in, scaled amplitude out.
);
  typedef struct packed {
    logic [7:0] result;
  } hlo_scl_state_t;

  hlo_scl_state_t q_ff;
  hlo_scl_state_t nxt_q;
  logic [15:0] prod;
  logic [15:0] quot;

  // Scaling holds output constant as supply drifts; a zero supply saturates.
  always_comb
  begin
    nxt_q = q_ff;
    prod = 16'(sh.amp) * 16'(HLO_SUPPLY_NOM);
    quot = (sh.supply == 8'h00) ? 16'(HLO_AMP_MAX) : prod / 16'(sh.supply);
    if (sh.comp_off)
    begin
      nxt_q.result = sh.amp;
    end
    else
    begin
      nxt_q.result = (quot > 16'(HLO_AMP_MAX)) ? HLO_AMP_MAX : quot[7:0];
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign sh.result = q_ff.result;
endmodule : hlo_scaler
`default_nettype wire

/* File: hlo_shape_if.sv */
// Carrier between the option register logic and the supply scaler.
// Assumes both ends share sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
interface hlo_shape_if;
  logic [7:0] amp;
  logic comp_off;
  logic [7:0] supply;
  logic [7:0] result;
  modport ctrl (output amp, output comp_off, output supply, input result);
  modport scaler (input amp, input comp_off, input supply, output result);
endinterface : hlo_shape_if
`default_nettype wire
